// >>> rtl/flcs_pkg.sv
package flcs_pkg;
  // fuse byte reset values (unprogrammed = 1)
  localparam logic [7:0] FLCS_BROWNOUT_RST = 8'hFF;
  localparam logic [7:0] FLCS_HIGH_RST = 8'h99;
  localparam logic [7:0] FLCS_CLOCK_RST = 8'h62;
  localparam logic [7:0] FLCS_LOCK_RST = 8'hFF;
  // lock byte bit positions
  localparam int FLCS_MEM_LOCK_A_BIT = 0;
  localparam int FLCS_MEM_LOCK_B_BIT = 1;
  localparam int FLCS_BOOT_LOCK_LO_BIT = 4;
  localparam int FLCS_BOOT_LOCK_HI_BIT = 5;
  // high fuse byte bit positions
  localparam int FLCS_EEPROM_PRESERVE_BIT = 3;
  localparam int FLCS_WATCHDOG_FORCED_BIT = 4;
  localparam int FLCS_SERIAL_PROG_BIT = 5;
  localparam int FLCS_DEBUG_ENABLE_BIT = 7;
  // clock fuse byte bit positions
  localparam int FLCS_CLOCK_OUT_BIT = 6;
  localparam int FLCS_CLOCK_SOURCE_MSB = 3;
  localparam logic [3:0] FLCS_CLOCK_SOURCE_RC8 = 4'h2;
  // crystal action codes
  localparam logic [1:0] FLCS_XA_ADDR = 2'h0;
  localparam logic [1:0] FLCS_XA_DATA = 2'h1;
  localparam logic [1:0] FLCS_XA_CMD = 2'h2;
  localparam logic [1:0] FLCS_XA_IDLE = 2'h3;
  // command bytes
  localparam logic [7:0] FLCS_CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] FLCS_CMD_WRITE_FUSE = 8'h40;
  localparam logic [7:0] FLCS_CMD_WRITE_LOCK = 8'h20;
  localparam logic [7:0] FLCS_CMD_READ_SIG = 8'h08;
  localparam logic [7:0] FLCS_CMD_READ_FUSE = 8'h04;
  // signature space
  localparam logic [1:0] FLCS_SIG_ADDR0 = 2'h0;
  localparam logic [1:0] FLCS_SIG_ADDR1 = 2'h1;
  localparam logic [1:0] FLCS_SIG_ADDR2 = 2'h2;
  // page geometry
  localparam int FLCS_PC_WORD_W = 6;
  localparam int FLCS_PC_PAGE_W = 7;
  localparam int FLCS_EE_BYTE_W = 2;
  localparam int FLCS_EE_PAGE_W = 7;
  // timing
  localparam int FLCS_CLK_MHZ = 20;
  localparam int FLCS_ERASE_NS = 9000;
  localparam int FLCS_ERASE_CYC = (FLCS_ERASE_NS * FLCS_CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    FLCS_ST_RUN = 2'b00,
    FLCS_ST_PROG = 2'b01,
    FLCS_ST_ERASE = 2'b11
  } flcs_state_t;
endpackage

// >>> rtl/flcs_sync.sv
`timescale 1ns/100ps
module flcs_sync import flcs_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_ff;
  logic [WIDTH-1:0] sync_ff;
  // first stage read only by second stage
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stage_ff <= '0;
      sync_ff <= '0;
    end else begin
      stage_ff <= async_in;
      sync_ff <= stage_ff;
    end
  end
  assign sync_out = sync_ff;
endmodule

// >>> rtl/flcs_store.sv
`timescale 1ns/100ps
module flcs_store import flcs_pkg::*; #(
  parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'h5A, // arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h3C, // arbitrary value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  // programming pins
  input wire logic prog_mode_in,
  input wire logic serial_mode_in,
  input wire logic crystal_input_pin_in,
  input wire logic crystal_action_b1_in,
  input wire logic crystal_action_b0_in,
  input wire logic byte_sel_in,
  input wire logic write_n_in,
  input wire logic [7:0] prog_data_in,
  output logic [7:0] prog_data_out,
  output logic ready_out,
  // core side
  input wire logic store_program_word_in,
  input wire logic load_program_word_in,
  input wire logic [12:0] prog_addr_in,
  input wire logic exec_in_boot_in,
  input wire logic [12:0] boot_start_in,
  input wire logic vectors_in_app_in,
  output logic store_allowed_out,
  output logic load_allowed_out,
  output logic irq_block_out,
  output logic [5:0] word_in_page_index_out,
  output logic [6:0] page_index_out,
  input wire logic [8:0] eeprom_addr_in,
  output logic [1:0] eeprom_byte_index_out,
  output logic [6:0] eeprom_page_index_out,
  // effective settings
  output logic [7:0] fuse_byte_brownout_out,
  output logic [7:0] fuse_byte_high_out,
  output logic [7:0] fuse_byte_clock_out,
  output logic [7:0] lock_byte_out,
  output logic [7:0] osc_trim_register_out,
  output logic eeprom_preserve_out,
  output logic eeprom_erase_out,
  output logic flash_erase_out,
  output logic watchdog_forced_on_out,
  output logic sleep_clock_keep_out,
  output logic clock_out_enable_out,
  output logic rc_8mhz_select_out
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [13:0] pins_sync;
  logic xtal_s, xa1_s, xa0_s, bs_s, wr_n_s, prog_s, serial_s;
  logic [7:0] data_s;
  // every pin sees the same two-flop delay, so data lines up with its strobe
  flcs_sync #(.WIDTH(14)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in({crystal_input_pin_in, crystal_action_b1_in, crystal_action_b0_in,
      byte_sel_in, ~write_n_in, prog_mode_in, serial_mode_in, prog_data_in[6:0]}),
    .sync_out(pins_sync)
  );
  logic data7_st_ff, data7_ff;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      data7_st_ff <= 1'b0;
      data7_ff <= 1'b0;
    end else begin
      data7_st_ff <= prog_data_in[7];
      data7_ff <= data7_st_ff;
    end
  end
  assign xtal_s = pins_sync[13];
  assign xa1_s = pins_sync[12];
  assign xa0_s = pins_sync[11];
  assign bs_s = pins_sync[10];
  assign wr_n_s = ~pins_sync[9];
  assign prog_s = pins_sync[8];
  assign serial_s = pins_sync[7];
  assign data_s = {data7_ff, pins_sync[6:0]};

  // edge detectors on synchronised levels
  // write strobe idles high, so its delay flop resets high: no false edge
  logic xtal_d_ff, wr_d_ff, prog_d_ff;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      xtal_d_ff <= 1'b0;
      wr_d_ff <= 1'b1;
      prog_d_ff <= 1'b0;
    end else begin
      xtal_d_ff <= xtal_s;
      wr_d_ff <= wr_n_s;
      prog_d_ff <= prog_s;
    end
  end
  logic xtal_rise, wr_fall, prog_enter, prog_exit;
  assign xtal_rise = xtal_s & ~xtal_d_ff;
  assign wr_fall = ~wr_n_s & wr_d_ff;
  assign prog_enter = prog_s & ~prog_d_ff;
  assign prog_exit = ~prog_s & prog_d_ff;

  // ****************************************
  // command, address, data loading
  // ****************************************
  logic [7:0] cmd_ff, addr_lo_ff, addr_hi_ff, data_lo_ff, data_hi_ff;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cmd_ff <= 8'h00;
      addr_lo_ff <= 8'h00;
      addr_hi_ff <= 8'h00;
      data_lo_ff <= 8'h00;
      data_hi_ff <= 8'h00;
    end else if (prog_s && xtal_rise) begin
      case ({xa1_s, xa0_s})
        FLCS_XA_ADDR: begin
          if (bs_s) begin
            addr_hi_ff <= data_s;
          end else begin
            addr_lo_ff <= data_s;
          end
        end
        FLCS_XA_DATA: begin
          if (bs_s) begin
            data_hi_ff <= data_s;
          end else begin
            data_lo_ff <= data_s;
          end
        end
        FLCS_XA_CMD: cmd_ff <= data_s;
        default: ;
      endcase
    end
  end

  // ****************************************
  // state, erase timer
  // ****************************************
  flcs_state_t state_ff;
  logic [15:0] erase_cnt_ff;
  logic erase_start;
  assign erase_start = (state_ff == FLCS_ST_PROG) && wr_fall && (cmd_ff == FLCS_CMD_CHIP_ERASE);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= FLCS_ST_RUN;
      erase_cnt_ff <= 16'h0000;
    end else begin
      case (state_ff)
        FLCS_ST_RUN: begin
          if (prog_enter) begin
            state_ff <= FLCS_ST_PROG;
          end
        end
        FLCS_ST_PROG: begin
          if (prog_exit) begin
            state_ff <= FLCS_ST_RUN;
          end else if (erase_start) begin
            state_ff <= FLCS_ST_ERASE;
            erase_cnt_ff <= 16'(FLCS_ERASE_CYC - 1);
          end
        end
        FLCS_ST_ERASE: begin
          if (erase_cnt_ff == 16'h0000) begin
            state_ff <= FLCS_ST_PROG;
          end else begin
            erase_cnt_ff <= erase_cnt_ff - 16'h0001;
          end
        end
        default: state_ff <= FLCS_ST_RUN;
      endcase
    end
  end
  // busy for exactly the erase count, then back to programming
  assign ready_out = (state_ff != FLCS_ST_ERASE);

  // ****************************************
  // stored fuse and lock cells
  // ****************************************
  logic [7:0] fuse_lo_ff, fuse_hi_ff, fuse_ex_ff, lock_ff;
  logic write_go, fuse_frozen;
  assign write_go = (state_ff == FLCS_ST_PROG) && wr_fall;
  assign fuse_frozen = ~lock_ff[FLCS_MEM_LOCK_A_BIT];
  // cells stand in for non-volatile storage; reset acts as first power-up
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fuse_lo_ff <= FLCS_CLOCK_RST;
      fuse_hi_ff <= FLCS_HIGH_RST;
      fuse_ex_ff <= FLCS_BROWNOUT_RST;
    end else if (write_go && cmd_ff == FLCS_CMD_WRITE_FUSE && !fuse_frozen) begin
      // chip erase has no path here, fuses survive it
      case ({bs_s, addr_lo_ff[0]})
        2'h0: fuse_lo_ff <= data_lo_ff;
        2'h2: begin
          fuse_hi_ff <= data_lo_ff;
          if (serial_s) begin
            fuse_hi_ff[FLCS_SERIAL_PROG_BIT] <= fuse_hi_ff[FLCS_SERIAL_PROG_BIT];
          end
        end
        2'h1: fuse_ex_ff <= {4'hF, data_lo_ff[3:0]};
        default: ; // lock byte only changes by its own command or by chip erase
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lock_ff <= FLCS_LOCK_RST;
    end else if (state_ff == FLCS_ST_ERASE && erase_cnt_ff == 16'h0000) begin
      lock_ff <= FLCS_LOCK_RST; // released only after erase done
    end else if (write_go && cmd_ff == FLCS_CMD_WRITE_LOCK) begin
      lock_ff <= lock_ff & {2'h3, data_lo_ff[5:0]}; // only programs bits
    end
  end

  // ****************************************
  // fuse latching
  // ****************************************
  logic [7:0] eff_lo_ff, eff_hi_ff, eff_ex_ff, trim_ff;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      eff_lo_ff <= FLCS_CLOCK_RST;
      eff_hi_ff <= FLCS_HIGH_RST;
      eff_ex_ff <= FLCS_BROWNOUT_RST;
      trim_ff <= 8'h00;
    end else if (state_ff == FLCS_ST_RUN) begin
      // normal mode relatches; programming entry freezes copy
      eff_lo_ff <= fuse_lo_ff;
      eff_hi_ff <= fuse_hi_ff;
      eff_ex_ff <= fuse_ex_ff;
      trim_ff <= CAL_BYTE;
    end
  end
  // decodes follow the latched copy, except the preserve bit
  assign eeprom_preserve_out = ~fuse_hi_ff[FLCS_EEPROM_PRESERVE_BIT]; // live
  assign eeprom_erase_out = erase_start & fuse_hi_ff[FLCS_EEPROM_PRESERVE_BIT];
  assign flash_erase_out = erase_start;
  assign watchdog_forced_on_out = ~eff_hi_ff[FLCS_WATCHDOG_FORCED_BIT];
  assign sleep_clock_keep_out = ~eff_hi_ff[FLCS_DEBUG_ENABLE_BIT];
  assign clock_out_enable_out = ~eff_lo_ff[FLCS_CLOCK_OUT_BIT];
  assign rc_8mhz_select_out =
    (eff_lo_ff[FLCS_CLOCK_SOURCE_MSB:0] == FLCS_CLOCK_SOURCE_RC8);
  assign fuse_byte_brownout_out = eff_ex_ff;
  assign fuse_byte_high_out = eff_hi_ff;
  assign fuse_byte_clock_out = eff_lo_ff;
  assign lock_byte_out = lock_ff;
  assign osc_trim_register_out = trim_ff;

  // ****************************************
  // programmer readback
  // ****************************************
  logic [7:0] rd_ff;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_ff <= 8'h00;
    end else if (cmd_ff == FLCS_CMD_READ_SIG && addr_hi_ff != 8'h00) begin
      rd_ff <= 8'h00; // outside the three-byte space
    end else if (cmd_ff == FLCS_CMD_READ_SIG) begin
      // signature readable regardless of locks
      if (bs_s) begin
        rd_ff <= CAL_BYTE;
      end else begin
        case (addr_lo_ff[1:0])
          FLCS_SIG_ADDR0: rd_ff <= SIG_BYTE0;
          FLCS_SIG_ADDR1: rd_ff <= SIG_BYTE1;
          FLCS_SIG_ADDR2: rd_ff <= SIG_BYTE2;
          default: rd_ff <= 8'h00;
        endcase
      end
    end else if (cmd_ff == FLCS_CMD_READ_FUSE) begin
      case ({bs_s, addr_lo_ff[0]}) // stored cells, zero means programmed
        2'h0: rd_ff <= fuse_lo_ff;
        2'h2: rd_ff <= fuse_hi_ff;
        2'h1: rd_ff <= fuse_ex_ff;
        default: rd_ff <= lock_ff;
      endcase
    end else begin
      rd_ff <= 8'h00;
    end
  end
  assign prog_data_out = rd_ff;

  // ****************************************
  // boot section protection
  // ****************************************
  logic in_boot;
  logic [1:0] blb;
  assign in_boot = (prog_addr_in >= boot_start_in);
  assign blb = {lock_ff[FLCS_BOOT_LOCK_HI_BIT], lock_ff[FLCS_BOOT_LOCK_LO_BIT]};
  // boot code reading boot is never refused
  always_comb begin
    store_allowed_out = store_program_word_in;
    load_allowed_out = load_program_word_in;
    irq_block_out = 1'b0;
    case (blb)
      2'b11: ;
      2'b10: store_allowed_out = store_program_word_in & ~in_boot;
      2'b00: begin
        store_allowed_out = store_program_word_in & ~in_boot;
        load_allowed_out = load_program_word_in & ~(in_boot & ~exec_in_boot_in);
        irq_block_out = vectors_in_app_in & exec_in_boot_in;
      end
      default: begin
        load_allowed_out = load_program_word_in & ~(in_boot & ~exec_in_boot_in);
        irq_block_out = vectors_in_app_in & exec_in_boot_in;
      end
    endcase
  end

  // ****************************************
  // page geometry
  // ****************************************
  assign word_in_page_index_out = prog_addr_in[FLCS_PC_WORD_W-1:0];
  assign page_index_out = prog_addr_in[FLCS_PC_WORD_W+FLCS_PC_PAGE_W-1:FLCS_PC_WORD_W];
  assign eeprom_byte_index_out = eeprom_addr_in[FLCS_EE_BYTE_W-1:0];
  assign eeprom_page_index_out =
    eeprom_addr_in[FLCS_EE_BYTE_W+FLCS_EE_PAGE_W-1:FLCS_EE_BYTE_W];
endmodule

// >>> testbench/flcs_store_assertions.sv
`timescale 1ns/100ps
module flcs_store_assertions import flcs_pkg::*; #(
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic store_program_word_in,
  input wire logic load_program_word_in,
  input wire logic [12:0] prog_addr_in,
  input wire logic exec_in_boot_in,
  input wire logic [12:0] boot_start_in,
  input wire logic vectors_in_app_in,
  input wire logic store_allowed_out,
  input wire logic load_allowed_out,
  input wire logic irq_block_out,
  input wire logic [5:0] word_in_page_index_out,
  input wire logic [6:0] page_index_out,
  input wire logic [8:0] eeprom_addr_in,
  input wire logic [1:0] eeprom_byte_index_out,
  input wire logic [6:0] eeprom_page_index_out,
  input wire logic [7:0] fuse_byte_high_out,
  input wire logic [7:0] fuse_byte_clock_out,
  input wire logic [7:0] lock_byte_out,
  input wire logic [7:0] osc_trim_register_out,
  input wire logic ready_out,
  input wire logic eeprom_preserve_out,
  input wire logic eeprom_erase_out,
  input wire logic flash_erase_out,
  input wire logic watchdog_forced_on_out,
  input wire logic sleep_clock_keep_out,
  input wire logic clock_out_enable_out,
  input wire logic rc_8mhz_select_out
);
  // ****
  // protection and decode checks
  // ****
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic in_boot;
  assign in_boot = prog_addr_in >= boot_start_in;
  a_boot_free: assert property (
    lock_byte_out[5:4] == 2'b11 && store_program_word_in && load_program_word_in && in_boot
    |-> store_allowed_out && load_allowed_out) else $error("boot access restricted");
  a_boot_store_block: assert property (
    store_program_word_in && in_boot && !lock_byte_out[FLCS_BOOT_LOCK_LO_BIT]
    |-> !store_allowed_out) else $error("boot store allowed");
  a_boot_load_block: assert property (
    load_program_word_in && in_boot && !exec_in_boot_in && !lock_byte_out[FLCS_BOOT_LOCK_HI_BIT]
    |-> !load_allowed_out) else $error("boot load allowed");
  a_irq_block: assert property (
    vectors_in_app_in && exec_in_boot_in && !lock_byte_out[FLCS_BOOT_LOCK_HI_BIT]
    |-> irq_block_out) else $error("irq not blocked");
  a_flash_index: assert property (
    1'b1 |-> word_in_page_index_out == prog_addr_in[5:0] && page_index_out == prog_addr_in[12:6])
    else $error("flash page split wrong");
  a_eeprom_index: assert property (
    1'b1 |-> {eeprom_page_index_out, eeprom_byte_index_out} == eeprom_addr_in)
    else $error("eeprom page split wrong");
  a_trim_load: assert property (
    $rose(rst_n_in) |=> osc_trim_register_out == CAL_BYTE) else $error("trim not loaded");
  a_erase_busy_time: assert property (
    $fell(ready_out) |-> ##179 !ready_out ##1 ready_out) else $error("erase busy length");
  a_erase_fuse_keep: assert property (
    !ready_out |-> $stable(fuse_byte_high_out) && $stable(fuse_byte_clock_out))
    else $error("fuse moved in erase");
  a_preserve_erase: assert property (
    flash_erase_out |-> eeprom_erase_out == !eeprom_preserve_out) else $error("eeprom erase wrong");
  // decode is combinational from the latched bytes, so it must match every cycle
  a_fuse_decode: assert property (
    1'b1
    |-> watchdog_forced_on_out == !fuse_byte_high_out[4] && sleep_clock_keep_out
    == !fuse_byte_high_out[7] && clock_out_enable_out == !fuse_byte_clock_out[6]
    && rc_8mhz_select_out == (fuse_byte_clock_out[3:0] == FLCS_CLOCK_SOURCE_RC8))
    else $error("fuse decode wrong");
endmodule
bind flcs_store flcs_store_assertions #(.CAL_BYTE(CAL_BYTE)) u_chk (.*);

// >>> testbench/flcs_programmer.sv
`timescale 1ns/100ps
module flcs_programmer (
  input wire logic clk_in,
  output logic xtal_out,
  output logic [1:0] xa_out,
  output logic bs_out,
  output logic wr_n_out,
  output logic [7:0] data_out
);
  // ****
  // parallel programmer
  // ****
  initial begin
    xtal_out = 1'b0;
    xa_out = 2'b11;
    bs_out = 1'b0;
    wr_n_out = 1'b1;
    data_out = 8'h00;
  end
  task automatic load(input logic [1:0] xa, input logic bs, input logic [7:0] d);
    @(negedge clk_in);
    xa_out = xa;
    bs_out = bs;
    data_out = d;
    @(negedge clk_in);
    xtal_out = 1'b1;
    repeat (4) @(negedge clk_in);
    xtal_out = 1'b0;
    repeat (4) @(negedge clk_in);
    xa_out = 2'b11;
    // released bus: never leave the last value standing
    data_out = ~d;
  endtask
  task automatic access(input logic [7:0] c, a, d, input logic b, w);
    load(2'b10, 1'b0, c);
    load(2'b00, 1'b0, a);
    if (w) load(2'b01, 1'b0, d);
    @(negedge clk_in);
    bs_out = b;
    repeat (4) @(negedge clk_in);
    if (w) begin
      wr_n_out = 1'b0;
      repeat (4) @(negedge clk_in);
      wr_n_out = 1'b1;
      repeat (6) @(negedge clk_in);
    end
  endtask
endmodule

// >>> testbench/fuse_lock_config_store_test.sv
`timescale 1ns/100ps
module fuse_lock_config_store_test import flcs_pkg::*;;
  localparam logic [7:0] SIG [3] = '{8'h3A, 8'hC5, 8'h17}; // arbitrary value
  localparam logic [7:0] CAL = 8'h6D; // arbitrary value
  logic clk_in = 1'b0, rst_n_in = 1'b0, prog_mode_in = 1'b0, serial_mode_in = 1'b0;
  logic store_program_word_in = 1'b1, load_program_word_in = 1'b1, exec_in_boot_in = 1'b0;
  logic vectors_in_app_in = 1'b1, crystal_input_pin_in, byte_sel_in, write_n_in;
  logic [1:0] xa;
  logic [7:0] prog_data_in, prog_data_out, fuse_byte_brownout_out, fuse_byte_high_out;
  logic [7:0] fuse_byte_clock_out, lock_byte_out, osc_trim_register_out;
  logic [12:0] prog_addr_in = 13'h1F00, boot_start_in = 13'h1C00;
  logic [8:0] eeprom_addr_in = 9'h1A6;
  logic [5:0] word_in_page_index_out;
  logic [6:0] page_index_out, eeprom_page_index_out;
  logic [1:0] eeprom_byte_index_out;
  logic ready_out, store_allowed_out, load_allowed_out, irq_block_out, eeprom_preserve_out;
  logic eeprom_erase_out, flash_erase_out, watchdog_forced_on_out, sleep_clock_keep_out;
  logic clock_out_enable_out, rc_8mhz_select_out, crystal_action_b1_in, crystal_action_b0_in;
  int errors = 0, tests_run = 0, fl_cnt = 0, ee_cnt = 0;
  assign {crystal_action_b1_in, crystal_action_b0_in} = xa;
  flcs_store #(.SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]), .CAL_BYTE(CAL)) uut (.*);
  flcs_programmer u_prog (.clk_in(clk_in), .xtal_out(crystal_input_pin_in), .xa_out(xa),
    .bs_out(byte_sel_in), .wr_n_out(write_n_in), .data_out(prog_data_in));
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    fl_cnt <= fl_cnt + int'(flash_erase_out === 1'b1);
    ee_cnt <= ee_cnt + int'(eeprom_erase_out === 1'b1);
  end
  // ****
  // tasks
  // ****
  task automatic chk(input string what, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wrf(input logic [7:0] c, d, input logic b);
    u_prog.access(c, 8'h00, d, b, 1'b1);
  endtask
  task automatic rd(input string what, input logic [7:0] c, a, input logic b, input logic [7:0] e);
    u_prog.access(c, a, 8'h00, b, 1'b0);
    chk(what, e, prog_data_out);
  endtask
  task automatic erase();
    wrf(FLCS_CMD_CHIP_ERASE, 8'h00, 1'b0);
    for (int n = 0; n < 400 && ready_out !== 1'b1; n++) @(negedge clk_in);
    if (ready_out !== 1'b1) begin
      errors++;
      report_and_stop();
    end
  endtask
  task automatic mode(input logic [7:0] lock, input logic [2:0] e);
    wrf(FLCS_CMD_WRITE_LOCK, lock, 1'b0);
    chk("lock byte", lock, lock_byte_out);
    exec_in_boot_in = 1'b0;
    @(negedge clk_in);
    chk("store load", {6'h00, e[2:1]}, {6'h00, store_allowed_out, load_allowed_out});
    exec_in_boot_in = 1'b1;
    @(negedge clk_in);
    chk("irq block", {7'h00, e[0]}, {7'h00, irq_block_out});
    prog_addr_in = 13'h0155;
    vectors_in_app_in = 1'b0;
    @(negedge clk_in);
    chk("app access", 8'h06, {5'h00, store_allowed_out, load_allowed_out, irq_block_out});
    chk("flash word", 8'h15, {2'h0, word_in_page_index_out});
    prog_addr_in = 13'h1F00;
    vectors_in_app_in = 1'b1;
  endtask
  task automatic sigs();
    for (int i = 0; i < 3; i++) rd("signature", FLCS_CMD_READ_SIG, 8'(i), 1'b0, SIG[i]);
    rd("calibration", FLCS_CMD_READ_SIG, 8'h00, 1'b1, CAL);
  endtask
  // ****
  // sequence
  // ****
  initial begin
    #3000000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    chk("trim", CAL, osc_trim_register_out);
    chk("decode", 8'h01, {4'h0, watchdog_forced_on_out, sleep_clock_keep_out,
      clock_out_enable_out, rc_8mhz_select_out});
    chk("flash page", 8'h7C, {1'b0, page_index_out});
    chk("eeprom page", 8'h69, {1'b0, eeprom_page_index_out});
    chk("eeprom byte", 8'h02, {6'h00, eeprom_byte_index_out});
    chk("brownout", FLCS_BROWNOUT_RST, fuse_byte_brownout_out);
    prog_mode_in = 1'b1;
    repeat (4) @(negedge clk_in);
    rd("brownout fuse", FLCS_CMD_READ_FUSE, 8'h01, 1'b0, FLCS_BROWNOUT_RST);
    rd("high fuse", FLCS_CMD_READ_FUSE, 8'h00, 1'b1, FLCS_HIGH_RST);
    u_prog.load(2'b11, 1'b1, 8'h00);
    chk("idle pulse", FLCS_HIGH_RST, prog_data_out);
    sigs();
    wrf(FLCS_CMD_WRITE_FUSE, 8'h01, 1'b1);
    wrf(FLCS_CMD_WRITE_FUSE, 8'h23, 1'b0);
    chk("high held", FLCS_HIGH_RST, fuse_byte_high_out);
    chk("preserve live", 8'h01, {7'h00, eeprom_preserve_out});
    prog_mode_in = 1'b0;
    repeat (6) @(negedge clk_in);
    chk("high latched", 8'h01, fuse_byte_high_out);
    chk("clock latched", 8'h23, fuse_byte_clock_out);
    chk("decode", 8'h0E, {4'h0, watchdog_forced_on_out, sleep_clock_keep_out,
      clock_out_enable_out, rc_8mhz_select_out});
    prog_mode_in = 1'b1;
    serial_mode_in = 1'b1;
    wrf(FLCS_CMD_WRITE_FUSE, 8'h21, 1'b1);
    serial_mode_in = 1'b0;
    rd("serial fuse", FLCS_CMD_READ_FUSE, 8'h00, 1'b1, 8'h01);
    mode(8'hFF, 3'b110);
    mode(8'hEF, 3'b010);
    mode(8'hCF, 3'b001);
    erase();
    chk("flash erased", 8'h01, fl_cnt[7:0]);
    chk("eeprom kept", 8'h00, ee_cnt[7:0]);
    chk("locks cleared", FLCS_LOCK_RST, lock_byte_out);
    rd("fuse after erase", FLCS_CMD_READ_FUSE, 8'h00, 1'b1, 8'h01);
    mode(8'hDF, 3'b101);
    wrf(FLCS_CMD_WRITE_LOCK, 8'hDE, 1'b0);
    wrf(FLCS_CMD_WRITE_FUSE, 8'h09, 1'b1);
    rd("locked fuse", FLCS_CMD_READ_FUSE, 8'h00, 1'b1, 8'h01);
    rd("lock read", FLCS_CMD_READ_FUSE, 8'h01, 1'b1, 8'hDE);
    sigs();
    erase();
    wrf(FLCS_CMD_WRITE_FUSE, 8'h09, 1'b1);
    chk("preserve off", 8'h00, {7'h00, eeprom_preserve_out});
    erase();
    chk("eeprom erased", 8'h01, ee_cnt[7:0]);
    report_and_stop();
  end
endmodule
